// *** core/cit_core_timing.v ***
// Instruction decoder and cycle sequencer for the pipelined 8-bit core.
// Contract
// - Cycle counts are valid with prefetch_enable set; otherwise undefined.
// - Code byte loads take four to seven clocks by alignment and read timing.
// - OR/XOR: register one clock, other operands two, immediate-to-direct three.
// - Accumulator clear, complement, rotates and swap: one byte, one clock.
// - Moves cost one clock per byte; indirect RAM forms take two.
// - Pointer load from sixteen-bit immediate: three bytes, three clocks.
// - External data moves: one byte, three clocks, eight or sixteen bit address.
// - Push and pop direct: two bytes, two clocks.
// - Exchange register one clock; direct, indirect and nibble exchange two.
// - Carry-only operations one clock; direct bit operations two clocks.
// - Carry and zero jumps: two clocks not taken, four taken.
// - Bit test jumps three or five; test-and-clear clears a set bit.
// - Compare-jump three or five; indirect form four or six.
// - Decrement-jump register two or four; direct three or five.
// - Short jump and indirect pointer jump take four clocks.
// - Relative offset is signed eight bits from next instruction address.
// - Direct below 0x80 addresses RAM, otherwise special-function registers.
// - Absolute forms replace low eleven bits in the page, four clocks.
// - Long forms carry sixteen-bit target, five clocks; returns six clocks.
// - Spare opcode 0xA5 behaves as one-byte, one-clock no-operation.
// - Registers R0-R7 of current bank; indirect uses R0 or R1 only.
// - Conditional branches finish two clocks sooner when not taken.
`timescale 1ns/1ps
`default_nettype none
`include "cit_defines.vh"
module cit_core_timing #(
   parameter PC_W = 16
) (
   input wire mclk_in,
   input wire arst_n_in,
   input wire prefetch_enable_in,
   input wire [2:0] flash_read_timing_in,
   input wire instr_valid_in,
   input wire [7:0] opcode_in,
   input wire [7:0] operand1_in,
   input wire [7:0] operand2_in,
   input wire [PC_W-1:0] pc_in,
   input wire [1:0] bank_sel_in,
   input wire branch_cond_in,
   output wire ready_out,
   output reg busy_out,
   output reg done_out,
   output reg [1:0] length_q_out,
   output reg [2:0] cycles_q_out,
   output reg branch_taken_out,
   output reg [PC_W-1:0] next_pc_out,
   output reg [4:0] reg_addr_out,
   output reg direct_is_sfr_out,
   output reg bit_clear_out,
   output reg timing_defined_out
);
   localparam ST_IDLE = 2'b01;
   localparam ST_EXEC = 2'b10;

   wire [1:0] base_len;
   wire [2:0] base_cyc;
   wire is_cond;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [2:0] count_q;
   reg [2:0] count_d;
   reg [2:0] cost;
   reg [1:0] tsel;
   reg taken;
   wire [15:0] seq_pc;
   wire [15:0] target;

   function [2:0] code_load_cost;
      input [2:0] frt;
      input align;
      reg [3:0] s;
      begin
         s = {1'b0, `CIT_CODE_LOAD_MIN} + {1'b0, frt} + {3'h0, align};
         if (s > {1'b0, `CIT_CODE_LOAD_MAX})
            code_load_cost = `CIT_CODE_LOAD_MAX;
         else
            code_load_cost = s[2:0];
      end
   endfunction

   cit_length_cost u_len (
      .opcode_in(opcode_in),
      .length_out(base_len),
      .cycles_out(base_cyc),
      .cond_branch_out(is_cond)
   );

   assign seq_pc = pc_in + {14'h0000, base_len};

   cit_target_calc u_tgt (
      .next_pc_in(seq_pc),
      .rel_in(base_len == 2'h3 ? operand2_in : operand1_in),
      .addr11_in({opcode_in[7:5], operand1_in}),
      .addr16_in({operand1_in, operand2_in}),
      .sel_in(tsel),
      .target_out(target)
   );

   // Untaken cost is the table base; taken conditionals add the fixed saving back.
   always @* begin
      tsel = 2'h3;
      taken = 1'b0;
      cost = base_cyc;
      if (is_cond || opcode_in == 8'h80) begin
         tsel = 2'h0;
         taken = is_cond ? branch_cond_in : 1'b1;
      end else if (opcode_in[4:0] == 5'h11 || opcode_in[4:0] == 5'h01) begin
         tsel = 2'h1;
         taken = 1'b1;
      end else if (opcode_in == 8'h12 || opcode_in == 8'h02) begin
         tsel = 2'h2;
         taken = 1'b1;
      end
      if (is_cond && branch_cond_in)
         cost = base_cyc + `CIT_NT_SAVING;
      if (opcode_in == 8'h93 || opcode_in == 8'h83)
         cost = code_load_cost(flash_read_timing_in, pc_in[0]);
   end

   assign ready_out = state_q[0];

   always @* begin
      state_d = state_q;
      count_d = count_q;
      case (state_q)
         ST_IDLE: begin
            if (instr_valid_in) begin
               count_d = cost - 3'h1;
               if (cost != 3'h1)
                  state_d = ST_EXEC;
            end
         end
         ST_EXEC: begin
            count_d = count_q - 3'h1;
            if (count_q == 3'h1)
               state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
            count_d = 3'h0;
         end
      endcase
   end

   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= ST_IDLE;
         count_q <= 3'h0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
         length_q_out <= 2'h0;
         cycles_q_out <= 3'h0;
         branch_taken_out <= 1'b0;
         next_pc_out <= {PC_W{1'b0}};
         reg_addr_out <= 5'h00;
         direct_is_sfr_out <= 1'b0;
         bit_clear_out <= 1'b0;
         timing_defined_out <= 1'b0;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
         busy_out <= (state_d == ST_EXEC);
         done_out <= (state_q == ST_IDLE && instr_valid_in && cost == 3'h1) ||
                     (state_q == ST_EXEC && count_q == 3'h1);
         bit_clear_out <= 1'b0;
         if (state_q == ST_IDLE && instr_valid_in) begin
            length_q_out <= base_len;
            cycles_q_out <= cost;
            branch_taken_out <= taken;
            next_pc_out <= taken ? target : seq_pc;
            // Indirect forms only ever use the low two bank registers.
            reg_addr_out <= {bank_sel_in, (opcode_in[3] ? opcode_in[2:0] : {2'b00, opcode_in[0]})};
            direct_is_sfr_out <= (operand1_in >= `CIT_SFR_LIMIT);
            bit_clear_out <= (opcode_in == 8'h10) && branch_cond_in;
            timing_defined_out <= prefetch_enable_in;
         end
      end
   end
endmodule
`default_nettype wire

// *** core/cit_defines.vh ***
// Shared constants for the instruction decode and timing block.
`ifndef CIT_DEFINES_VH
`define CIT_DEFINES_VH
`define CIT_CYC_W 3
`define CIT_LEN_W 2
`define CIT_NT_SAVING 3'h2
`define CIT_CODE_LOAD_MIN 3'h4
`define CIT_CODE_LOAD_MAX 3'h7
`define CIT_SFR_LIMIT 8'h80
`define CIT_SPARE_OPCODE 8'hA5
`define CIT_NOP_OPCODE 8'h00
`define CIT_PAGE_MASK 16'hF800
`define CIT_PC_W 16
`endif

// *** core/cit_length_cost.v ***
// Opcode to instruction length and base clock cost lookup.
`timescale 1ns/1ps
`default_nettype none
module cit_length_cost (
   input wire [7:0] opcode_in,
   output reg [1:0] length_out,
   output reg [2:0] cycles_out,
   output reg cond_branch_out
);
   always @* begin
      length_out = 2'h1;
      cycles_out = 3'h1;
      cond_branch_out = 1'b0;
      casez (opcode_in)
         // Register forms and one-byte accumulator, carry and exchange operations.
         8'b0100_1???, 8'b0110_1???, 8'b1110_1???, 8'b1111_1???, 8'b1100_1???: begin
            length_out = 2'h1;
            cycles_out = 3'h1;
         end
         8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'hC3, 8'hD3, 8'hB3, 8'h00, 8'hA5: begin
            length_out = 2'h1;
            cycles_out = 3'h1;
         end
         8'b0100_011?, 8'b0110_011?, 8'b1110_011?, 8'b1111_011?, 8'b1100_011?, 8'b1101_011?: begin
            length_out = 2'h1;
            cycles_out = 3'h2;
         end
         8'h42, 8'h62, 8'h44, 8'h64, 8'hE5, 8'hE6, 8'h74, 8'hF5, 8'hC0, 8'hD0, 8'hC5,
         8'b1010_1???, 8'b0111_1???, 8'b1000_1???, 8'b1010_011?, 8'b0111_011?, 8'b1000_011?,
         8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92, 8'h52, 8'h54: begin
            length_out = 2'h2;
            cycles_out = 3'h2;
         end
         8'h43, 8'h63, 8'h85, 8'h75, 8'h90, 8'h53: begin
            length_out = 2'h3;
            cycles_out = 3'h3;
         end
         8'hE0, 8'hF0, 8'b1110_001?, 8'b1111_001?: begin
            length_out = 2'h1;
            cycles_out = 3'h3;
         end
         8'h93, 8'h83: begin
            length_out = 2'h1;
            cycles_out = `CIT_CODE_LOAD_MIN;
         end
         8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???: begin
            length_out = 2'h2;
            cycles_out = 3'h2;
            cond_branch_out = 1'b1;
         end
         8'h20, 8'h30, 8'h10, 8'hB5, 8'hB4, 8'b1011_1???, 8'hD5: begin
            length_out = 2'h3;
            cycles_out = 3'h3;
            cond_branch_out = 1'b1;
         end
         8'b1011_011?: begin
            length_out = 2'h3;
            cycles_out = 3'h4;
            cond_branch_out = 1'b1;
         end
         8'b???1_0001, 8'b???0_0001, 8'h80: begin
            length_out = 2'h2;
            cycles_out = 3'h4;
         end
         8'h73: begin
            length_out = 2'h1;
            cycles_out = 3'h4;
         end
         8'h12, 8'h02: begin
            length_out = 2'h3;
            cycles_out = 3'h5;
         end
         8'h22, 8'h32: begin
            length_out = 2'h1;
            cycles_out = 3'h6;
         end
         default: begin
            length_out = 2'h2;
            cycles_out = 3'h2;
         end
      endcase
   end
endmodule
`default_nettype wire

// *** core/cit_target_calc.v ***
// Branch target computation for relative, absolute and long forms.
`timescale 1ns/1ps
`default_nettype none
module cit_target_calc (
   input wire [15:0] next_pc_in,
   input wire [7:0] rel_in,
   input wire [10:0] addr11_in,
   input wire [15:0] addr16_in,
   input wire [1:0] sel_in,
   output reg [15:0] target_out
);
   always @* begin
      case (sel_in)
         2'h0: target_out = next_pc_in + {{8{rel_in[7]}}, rel_in};
         2'h1: target_out = (next_pc_in & `CIT_PAGE_MASK) | {5'h00, addr11_in};
         2'h2: target_out = addr16_in;
         default: target_out = next_pc_in;
      endcase
   end
endmodule
`default_nettype wire

// *** verification/cit_timing_sva.sv ***
// Checker for decode and cycle timing of the core.
`timescale 1ns/1ps
`default_nettype none
module cit_timing_sva (
   input wire logic mclk_in,
   input wire logic arst_n_in,
   input wire logic instr_valid_in,
   input wire logic [7:0] opcode_in,
   input wire logic [7:0] operand1_in,
   input wire logic [7:0] operand2_in,
   input wire logic [15:0] pc_in,
   input wire logic [1:0] bank_sel_in,
   input wire logic branch_cond_in,
   input wire logic ready_out,
   input wire logic done_out,
   input wire logic [2:0] cycles_q_out,
   input wire logic [15:0] next_pc_out,
   input wire logic [4:0] reg_addr_out,
   input wire logic direct_is_sfr_out,
   input wire logic bit_clear_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   sequence s_go(logic [7:0] op);
      ready_out && instr_valid_in && opcode_in == op;
   endsequence
   sequence s_two;
      !done_out ##1 done_out;
   endsequence
   sequence s_four;
      !done_out[*3] ##1 done_out;
   endsequence
   a_spare_nop: assert property (s_go(8'hA5) |=> done_out && cycles_q_out == 3'h1)
      else $error("spare opcode cost");
   a_jc_fall: assert property (s_go(8'h40) ##0 !branch_cond_in |=> s_two)
      else $error("branch not taken cost");
   a_jc_take: assert property (s_go(8'h40) ##0 branch_cond_in |=> s_four)
      else $error("branch taken cost");
   a_ret_six: assert property (s_go(8'h22) |=> !done_out[*5] ##1 done_out)
      else $error("return cost");
   a_rel_dest: assert property (s_go(8'h80) |=>
      next_pc_out == 16'($past(pc_in) + 16'h2 + 16'($signed($past(operand1_in)))))
      else $error("relative target");
   a_long_dest: assert property (s_go(8'h02) |=> next_pc_out == {$past(operand1_in), $past(operand2_in)})
      else $error("long target");
   a_sfr_split: assert property (ready_out && instr_valid_in |=>
      direct_is_sfr_out == ($past(operand1_in) >= 8'h80))
      else $error("direct space split");
   a_bank_reg: assert property (ready_out && instr_valid_in && opcode_in[7:3] == 5'h1D |=>
      reg_addr_out[4:3] == $past(bank_sel_in) && {5'h1D, reg_addr_out[2:0]} == $past(opcode_in))
      else $error("register select");
   a_test_clear: assert property (s_go(8'h10) ##0 branch_cond_in |=> bit_clear_out)
      else $error("bit clear missing");
endmodule
bind cit_core_timing cit_timing_sva u_sva (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .instr_valid_in(instr_valid_in),
   .opcode_in(opcode_in), .operand1_in(operand1_in), .operand2_in(operand2_in), .pc_in(pc_in),
   .bank_sel_in(bank_sel_in), .branch_cond_in(branch_cond_in), .ready_out(ready_out), .done_out(done_out),
   .cycles_q_out(cycles_q_out), .next_pc_out(next_pc_out), .reg_addr_out(reg_addr_out),
   .direct_is_sfr_out(direct_is_sfr_out), .bit_clear_out(bit_clear_out));
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for instruction decode and cycle timing.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0, rst_n = 1'b0, pf = 1'b1, vld = 1'b0, cond = 1'b0;
   logic [2:0] frt = 3'h0;
   logic [7:0] op = 8'h00, o1 = 8'h00, o2 = 8'h00;
   logic [15:0] pcv = 16'h1000;
   logic [1:0] bank = 2'h0;
   wire logic rdy, busy, done, tkn, sfr, bclr, tdef;
   wire logic [1:0] len;
   wire logic [2:0] cyc;
   wire logic [15:0] npc;
   wire logic [4:0] radr;
   int n_errors = 0, comparisons = 0, n;
   always #12.5 clk = ~clk;
   cit_core_timing uut (.mclk_in(clk), .arst_n_in(rst_n), .prefetch_enable_in(pf), .flash_read_timing_in(frt),
      .instr_valid_in(vld), .opcode_in(op), .operand1_in(o1), .operand2_in(o2), .pc_in(pcv), .bank_sel_in(bank),
      .branch_cond_in(cond), .ready_out(rdy), .busy_out(busy), .done_out(done), .length_q_out(len),
      .cycles_q_out(cyc), .branch_taken_out(tkn), .next_pc_out(npc), .reg_addr_out(radr),
      .direct_is_sfr_out(sfr), .bit_clear_out(bclr), .timing_defined_out(tdef));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Issues one instruction and counts clocks until its completion pulse.
   task automatic step(input logic [7:0] a, b, c, input logic t, input int l, k);
      @(posedge clk);
      vld <= 1'b1;
      op <= a;
      o1 <= b;
      o2 <= c;
      cond <= t;
      @(posedge clk);
      vld <= 1'b0;
      n = 1;
      #1;
      chk("busy", busy, 16'(k > 1));
      while (done !== 1'b1 && n < 9) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (done !== 1'b1) begin
         n_errors++;
         close_out();
      end
      chk("clocks", 16'(n), 16'(k));
      chk("cost", cyc, 16'(k));
      chk("length", len, 16'(l));
   endtask
   task automatic t_plain;
      logic [15:0] t[$] = '{16'h0011, 16'hA511, 16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
         16'hC411, 16'h4811, 16'h4612, 16'h4422, 16'h4333, 16'h6333, 16'hE811, 16'hE612, 16'hF612, 16'h8533,
         16'h7533, 16'h9033, 16'hE013, 16'hE213, 16'hF013, 16'hF213, 16'hC022, 16'hD022, 16'hC911, 16'hC522,
         16'hC612, 16'hD612, 16'hC311, 16'hB311, 16'hD222, 16'hB022, 16'h7222};
      foreach (t[i]) step(t[i][15:8], 8'h05, 8'h06, 1'b0, t[i][7:4], t[i][3:0]);
      $display("t_plain end");
   endtask
   task automatic t_branch;
      logic [15:0] t[$] = '{16'h4022, 16'h5022, 16'h6022, 16'h7022, 16'hD822, 16'h2033, 16'h3033, 16'h1033,
         16'hB433, 16'hB533, 16'hBF33, 16'hD533, 16'hB634};
      foreach (t[i]) for (int c = 0; c < 2; c++) begin
         step(t[i][15:8], 8'hF0, 8'hF0, c[0], t[i][7:4], t[i][3:0] + 2 * c);
         chk("target", npc, pcv + t[i][7:4] + (c ? 16'hFFF0 : 16'h0));
         chk("taken", tkn, c[0]);
      end
      $display("t_branch end");
   endtask
   task automatic t_jumps;
      step(8'h80, 8'hF0, 8'h00, 1'b0, 2, 4);
      chk("target", npc, pcv + 16'hFFF2);
      step(8'h73, 8'h00, 8'h00, 1'b0, 1, 4);
      step(8'h12, 8'hAB, 8'hCD, 1'b0, 3, 5);
      chk("target", npc, 16'hABCD);
      step(8'h32, 8'h00, 8'h00, 1'b0, 1, 6);
      @(posedge clk);
      pcv <= 16'h17FE;
      step(8'hE1, 8'h5A, 8'h00, 1'b0, 2, 4);
      chk("target", npc, 16'h1F5A);
      step(8'h11, 8'h5A, 8'h00, 1'b0, 2, 4);
      chk("target", npc, 16'h185A);
      $display("t_jumps end");
   endtask
   task automatic t_load;
      for (int f = 0; f < 4; f++) begin
         @(posedge clk);
         frt <= f[2:0];
         pcv <= 16'h1000 + 16'(f);
         step(f[0] ? 8'h83 : 8'h93, 8'h00, 8'h00, 1'b0, 1, (f == 3) ? 7 : 4 + f + f % 2);
      end
      $display("t_load end");
   endtask
   task automatic t_oper;
      @(posedge clk);
      bank <= 2'h2;
      step(8'hE7, 8'h05, 8'h00, 1'b0, 1, 2);
      chk("register", radr, 16'h11);
      chk("sfr", sfr, 16'h0);
      chk("defined", tdef, 16'h1);
      @(posedge clk);
      pf <= 1'b0;
      step(8'hED, 8'h80, 8'h00, 1'b0, 1, 1);
      chk("register", radr, 16'h15);
      chk("sfr", sfr, 16'h1);
      chk("defined", tdef, 16'h0);
      $display("t_oper end");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_plain();
      t_branch();
      t_jumps();
      t_load();
      t_oper();
      close_out();
   end
endmodule
`default_nettype wire
